// *** design/eplc_pkg.sv ***
package eplc_pkg;
   // indirect select register layout
   localparam logic [2:0] SEL_SPACE_EEE   = 3'h1;
   localparam int         SEL_SPACE_LSB   = 5;
   localparam int         SEL_RW_BIT      = 4;
   localparam logic [3:0] PORT_FIRST      = 4'h1;
   localparam logic [3:0] PORT_LAST       = 4'h3;
   // indirect byte offsets
   localparam logic [7:0] OFS_CTRL_HI     = 8'h2c;
   localparam logic [7:0] OFS_CTRL_LO     = 8'h2d;
   localparam logic [7:0] OFS_RECOV_HI    = 8'h2e;
   localparam logic [7:0] OFS_RECOV_LO    = 8'h2f;
   // control register fields
   localparam int         BIT_TEN_OFF     = 15;
   localparam int         BIT_HW_XCHG     = 7;
   localparam int         BIT_HW_STAT     = 6;
   localparam int         BIT_TX_STICKY   = 5;
   localparam int         BIT_TX_NOW      = 4;
   localparam int         BIT_RX_STICKY   = 3;
   localparam int         BIT_RX_NOW      = 2;
   localparam int         BIT_SW_SEL      = 1;
   localparam int         BIT_FAST_EN     = 0;
   // reset values
   localparam logic       RST_TEN_OFF     = 1'b1;
   localparam logic       RST_HW_XCHG     = 1'b1;
   localparam logic       RST_SW_SEL      = 1'b0;
   localparam logic       RST_FAST_EN     = 1'b0;
   localparam logic [7:0] RST_RECOV       = 8'h27;
   localparam logic [7:0] RECOV_HI_READ   = 8'h01;
   // timing
   localparam real        CLK_NS          = 40.0;
   localparam real        TICK_NS         = 640.0;
   localparam int         TICK_CYCLES     = int'(TICK_NS / CLK_NS);
endpackage

// *** design/eplc_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module eplc_sync3 (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // level
   input  wire logic din,
   output logic      dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // change accepted once stages two and three agree
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout <= s3_q;
         end
      end
   end
endmodule
`default_nettype wire

// *** design/eplc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - bit 15 one (reset) disables 10BASE-T low power; zero enables it.
// - bit 7 one (reset) with bit 1 zero: hardware exchanges capability by next page.
// - matching hardware exchange sets the 100BASE-TX enable bit 0.
// - bit 7 zero: no hardware exchange; software does the exchange.
// - read-only bit 6: enable came from hardware exchange; resets zero.
// - sticky bit 5 sets on transmit idle, cleared by reading it.
// - bit 4 is the live transmit idle indication.
// - sticky bit 3 sets on receive idle, cleared by reading it.
// - bit 2 is the live receive idle indication.
// - bit 1 one takes enable from software bit 0, else from negotiation.
// - bit 0 enables 100BASE-TX low power; software or hardware sets it.
// - MAC waits the 8-bit recovery time after idle before transmitting.
// - recovery unit is 640 ns, reset value 0x27.
// - select bits 7:5 equal 001 choose this register space.
// - select bits 3:0 give port 1 to 3, routing to that copy.
// - recovery register upper byte at 0x2e, lower byte at 0x2f.
// - control register lower byte at 0x2d, upper byte at 0x2c.
// - writing the offset register triggers an indirect read; a write lands with the data byte.
module eplc_top #(
   parameter int NPORT = 3
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // indirect window: select, offset and data byte writes
   input  wire logic             sel_wr,
   input  wire logic [7:0]       sel_wdata,
   input  wire logic             ofs_wr,
   input  wire logic [7:0]       ofs_wdata,
   input  wire logic             data_wr,
   input  wire logic [7:0]       data_wdata,
   output logic [7:0]            data_rdata,
   // per-port phy status, asynchronous levels
   input  wire logic [NPORT-1:0] tx_idle_pin,
   input  wire logic [NPORT-1:0] rx_idle_pin,
   input  wire logic [NPORT-1:0] np_match_pin,
   // per-port control outputs
   output logic [NPORT-1:0]      ten_base_low_power_off,
   output logic [NPORT-1:0]      fast_low_power_on,
   output logic [NPORT-1:0]      hw_exchange_run,
   output logic [NPORT-1:0]      mac_tx_hold
);
   logic [7:0]       sel_q;
   logic [7:0]       ofs_q;
   logic [NPORT-1:0] tx_now;
   logic [NPORT-1:0] rx_now;
   logic [NPORT-1:0] match_now;
   logic [NPORT-1:0] ten_off_q;
   logic [NPORT-1:0] hw_xchg_q;
   logic [NPORT-1:0] hw_stat_q;
   logic [NPORT-1:0] tx_sticky_q;
   logic [NPORT-1:0] rx_sticky_q;
   logic [NPORT-1:0] sw_sel_q;
   logic [NPORT-1:0] fast_en_q;
   logic [7:0]       recov_q [NPORT];
   logic [7:0]       wait_q [NPORT];
   logic [NPORT-1:0] idle_prev_q;
   logic [7:0]       tick_q;
   logic             tick;
   logic             space_ok;
   logic [3:0]       port_num;
   logic [1:0]       pidx;
   logic             rd_go;
   logic             wr_go;

   // synchronise asynchronous phy levels
   for (genvar g = 0; g < NPORT; g++) begin : g_sync
      eplc_sync3 u_tx (
         .sys_clk (sys_clk),
         .nrst    (nrst),
         .din     (tx_idle_pin[g]),
         .dout    (tx_now[g])
      );
      eplc_sync3 u_rx (
         .sys_clk (sys_clk),
         .nrst    (nrst),
         .din     (rx_idle_pin[g]),
         .dout    (rx_now[g])
      );
      eplc_sync3 u_np (
         .sys_clk (sys_clk),
         .nrst    (nrst),
         .din     (np_match_pin[g]),
         .dout    (match_now[g])
      );
   end

   // window decode
   assign space_ok = (sel_q[7:5] == eplc_pkg::SEL_SPACE_EEE) &&
                     (port_num >= eplc_pkg::PORT_FIRST) &&
                     (port_num <= eplc_pkg::PORT_LAST) &&
                     (port_num <= 4'(NPORT));
   assign port_num = sel_q[3:0];
   assign pidx     = 2'(port_num - 4'h1);
   // read triggered by the offset write; write lands with the data byte
   assign rd_go    = ofs_wr && space_ok &&
                     sel_q[eplc_pkg::SEL_RW_BIT];
   assign wr_go    = data_wr && space_ok &&
                     !sel_q[eplc_pkg::SEL_RW_BIT];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sel_q <= 8'h00;
         ofs_q <= 8'h00;
      end else begin
         if (sel_wr) begin
            sel_q <= sel_wdata;
         end
         if (ofs_wr) begin
            ofs_q <= ofs_wdata;
         end
      end
   end

   // read data latched at trigger time
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         data_rdata <= 8'h00;
      end else if (rd_go) begin
         case (ofs_wdata)
            eplc_pkg::OFS_CTRL_HI:  data_rdata <= {ten_off_q[pidx],
                                                  7'h00};
            eplc_pkg::OFS_CTRL_LO:  data_rdata <= {hw_xchg_q[pidx],
                                                  hw_stat_q[pidx],
                                                  tx_sticky_q[pidx],
                                                  tx_now[pidx],
                                                  rx_sticky_q[pidx],
                                                  rx_now[pidx],
                                                  sw_sel_q[pidx],
                                                  fast_en_q[pidx]};
            eplc_pkg::OFS_RECOV_HI: data_rdata <=
               eplc_pkg::RECOV_HI_READ;
            eplc_pkg::OFS_RECOV_LO: data_rdata <= recov_q[pidx];
            default:                data_rdata <= 8'h00;
         endcase
      end
   end

   // 640 ns tick divider
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tick_q <= 8'h00;
         tick   <= 1'b0;
      end else if (tick_q == 8'(eplc_pkg::TICK_CYCLES - 1)) begin
         tick_q <= 8'h00;
         tick   <= 1'b1;
      end else begin
         tick_q <= tick_q + 8'h01;
         tick   <= 1'b0;
      end
   end

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic sel_me;
      logic rd_lo;
      assign sel_me = (pidx == 2'(p));
      assign rd_lo  = rd_go && sel_me && (ofs_wdata == eplc_pkg::OFS_CTRL_LO);

      // software-written control fields
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            ten_off_q[p] <= eplc_pkg::RST_TEN_OFF;
            hw_xchg_q[p] <= eplc_pkg::RST_HW_XCHG;
            sw_sel_q[p]  <= eplc_pkg::RST_SW_SEL;
            recov_q[p]   <= eplc_pkg::RST_RECOV;
         end else if (wr_go && sel_me) begin
            if (ofs_q == eplc_pkg::OFS_CTRL_HI) begin
               ten_off_q[p] <= data_wdata[7];
            end
            if (ofs_q == eplc_pkg::OFS_CTRL_LO) begin
               hw_xchg_q[p] <= data_wdata[eplc_pkg::BIT_HW_XCHG];
               sw_sel_q[p]  <= data_wdata[eplc_pkg::BIT_SW_SEL];
            end
            if (ofs_q == eplc_pkg::OFS_RECOV_LO) begin
               recov_q[p] <= data_wdata;
            end
         end
      end

      // enable bit: software write or hardware match
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            fast_en_q[p] <= eplc_pkg::RST_FAST_EN;
            hw_stat_q[p] <= 1'b0;
         end else begin
            if (wr_go && sel_me && ofs_q == eplc_pkg::OFS_CTRL_LO) begin
               fast_en_q[p] <= data_wdata[eplc_pkg::BIT_FAST_EN];
            end else if (hw_xchg_q[p] && match_now[p]) begin
               fast_en_q[p] <= 1'b1;
            end
            // bit 7 off: no hardware-derived status
            hw_stat_q[p] <= hw_xchg_q[p] && match_now[p];
         end
      end

      // sticky idle flags; a new event beats the read clear
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            tx_sticky_q[p] <= 1'b0;
            rx_sticky_q[p] <= 1'b0;
         end else begin
            if (tx_now[p]) begin
               tx_sticky_q[p] <= 1'b1;
            end else if (rd_lo) begin
               tx_sticky_q[p] <= 1'b0;
            end
            if (rx_now[p]) begin
               rx_sticky_q[p] <= 1'b1;
            end else if (rd_lo) begin
               rx_sticky_q[p] <= 1'b0;
            end
         end
      end

      // wake wait counter
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            idle_prev_q[p] <= 1'b0;
            wait_q[p]      <= 8'h00;
            mac_tx_hold[p] <= 1'b0;
         end else begin
            idle_prev_q[p] <= tx_now[p];
            if (tx_now[p]) begin
               wait_q[p]      <= 8'h00;
               mac_tx_hold[p] <= 1'b1;
            end else if (idle_prev_q[p]) begin
               wait_q[p]      <= recov_q[p];
               mac_tx_hold[p] <= (recov_q[p] != 8'h00);
            end else if (tick && wait_q[p] != 8'h00) begin
               wait_q[p]      <= wait_q[p] - 8'h01;
               mac_tx_hold[p] <= (wait_q[p] != 8'h01);
            end
         end
      end
   end

   // registered control outputs
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ten_base_low_power_off <= '1;
         fast_low_power_on      <= '0;
         hw_exchange_run        <= '1;
      end else begin
         ten_base_low_power_off <= ten_off_q;
         hw_exchange_run        <= hw_xchg_q & ~sw_sel_q;
         for (int i = 0; i < NPORT; i++) begin
            fast_low_power_on[i] <= sw_sel_q[i] ? fast_en_q[i]
                                               : hw_stat_q[i] | fast_en_q[i];
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/eplc_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module eplc_top_chk #(
   parameter int NPORT = 3
) (
   // clock, reset and window
   input wire logic             sys_clk,
   input wire logic             nrst,
   input wire logic             sel_wr,
   input wire logic [7:0]       sel_wdata,
   input wire logic             ofs_wr,
   input wire logic [7:0]       ofs_wdata,
   input wire logic             data_wr,
   input wire logic [7:0]       data_wdata,
   input wire logic [7:0]       data_rdata,
   // phy status and control
   input wire logic [NPORT-1:0] tx_idle_pin,
   input wire logic [NPORT-1:0] rx_idle_pin,
   input wire logic [NPORT-1:0] np_match_pin,
   input wire logic [NPORT-1:0] ten_base_low_power_off,
   input wire logic [NPORT-1:0] fast_low_power_on,
   input wire logic [NPORT-1:0] hw_exchange_run,
   input wire logic [NPORT-1:0] mac_tx_hold
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_idle_long;
      tx_idle_pin[0] [*6];
   endsequence
   sequence s_quiet;
      !tx_idle_pin[0] [*8] ##0 !mac_tx_hold[0];
   endsequence
   a_reset_outs_ok: assert property ($rose(nrst) |->
      ten_base_low_power_off == '1 && hw_exchange_run == '1 &&
      fast_low_power_on == '0 && mac_tx_hold == '0)
      else $error("outputs wrong after reset");
   a_hold_in_idle: assert property (s_idle_long |-> mac_tx_hold[0])
      else $error("transmit not held in idle");
   a_hold_stays_low: assert property (s_quiet |=> !mac_tx_hold[0])
      else $error("hold raised without idle");
   a_ten_off_cause: assert property (
      !$stable(ten_base_low_power_off) |->
      $past(data_wr) || $past(data_wr, 2))
      else $error("ten base bit moved without write");
   a_hw_run_cause: assert property (
      !$stable(hw_exchange_run) |->
      $past(data_wr) || $past(data_wr, 2))
      else $error("exchange run moved without write");
   a_rdata_cause: assert property ($changed(data_rdata) |->
      $past(ofs_wr) || $past(ofs_wr, 2))
      else $error("read data moved without offset write");
   a_match_sets_fast: assert property (
      (hw_exchange_run[0] && np_match_pin[0] && !data_wr) [*8]
      |-> fast_low_power_on[0])
      else $error("match did not enable");
   a_fast_rise_why: assert property ($rose(fast_low_power_on[0]) |->
      $past(data_wr) || $past(data_wr, 2) || $past(np_match_pin[0], 3) ||
      $past(np_match_pin[0], 4) || $past(np_match_pin[0], 5) ||
      $past(np_match_pin[0], 6))
      else $error("enable rose without cause");
endmodule
bind eplc_top eplc_top_chk #(.NPORT(NPORT)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .sel_wr(sel_wr), .sel_wdata(sel_wdata),
   .ofs_wr(ofs_wr), .ofs_wdata(ofs_wdata), .data_wr(data_wr),
   .data_wdata(data_wdata), .data_rdata(data_rdata),
   .tx_idle_pin(tx_idle_pin), .rx_idle_pin(rx_idle_pin),
   .np_match_pin(np_match_pin),
   .ten_base_low_power_off(ten_base_low_power_off),
   .fast_low_power_on(fast_low_power_on),
   .hw_exchange_run(hw_exchange_run), .mac_tx_hold(mac_tx_hold));
`default_nettype wire

// *** verification/eplc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module eplc_host (
   // clock
   input  wire logic       sys_clk,
   // indirect window
   output logic            sel_wr,
   output logic [7:0]      sel_wdata,
   output logic            ofs_wr,
   output logic [7:0]      ofs_wdata,
   output logic            data_wr,
   output logic [7:0]      data_wdata,
   input  wire logic [7:0] data_rdata
);
   initial begin
      {sel_wr, ofs_wr, data_wr} = 3'h0;
      {sel_wdata, ofs_wdata, data_wdata} = 24'h0;
   end
   // released bytes flip so a stale value is never mistaken for fresh
   task automatic put(input logic [2:0] k, input logic [7:0] v);
      @(negedge sys_clk);
      {sel_wr, ofs_wr, data_wr} = k;
      {sel_wdata, ofs_wdata, data_wdata} = {3{v}};
      @(negedge sys_clk);
      {sel_wr, ofs_wr, data_wr} = 3'h0;
      {sel_wdata, ofs_wdata, data_wdata} = {3{~v}};
   endtask
   task automatic wr(input logic [7:0] s, input logic [7:0] o,
                     input logic [7:0] v);
      put(3'h4, s);
      put(3'h2, o);
      put(3'h1, v);
   endtask
   task automatic rd(input logic [3:0] p, input logic [7:0] o,
                     output logic [7:0] v);
      put(3'h4, {3'h1, 1'b1, p});
      put(3'h2, o);
      repeat (2) @(negedge sys_clk);
      v = data_rdata;
   endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       sys_clk, nrst, sel_wr, ofs_wr, data_wr;
   logic [7:0] sel_wdata, ofs_wdata, data_wdata, data_rdata;
   logic [2:0] tx_idle_pin, rx_idle_pin, np_match_pin, mac_tx_hold;
   logic [2:0] ten_base_low_power_off, fast_low_power_on, hw_exchange_run;
   int         fail_count = 0, checks = 0, cyc = 0;
   eplc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .sel_wr(sel_wr),
      .sel_wdata(sel_wdata), .ofs_wr(ofs_wr), .ofs_wdata(ofs_wdata),
      .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata),
      .tx_idle_pin(tx_idle_pin), .rx_idle_pin(rx_idle_pin),
      .np_match_pin(np_match_pin), .mac_tx_hold(mac_tx_hold),
      .ten_base_low_power_off(ten_base_low_power_off),
      .fast_low_power_on(fast_low_power_on),
      .hw_exchange_run(hw_exchange_run));
   eplc_host u_host (.sys_clk(sys_clk), .sel_wr(sel_wr),
      .sel_wdata(sel_wdata), .ofs_wr(ofs_wr), .ofs_wdata(ofs_wdata),
      .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));
   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, s);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input int p, input logic [7:0] o, e);
      logic [7:0] v;
      u_host.rd(4'(p), o, v);
      chk("read byte", e, v);
   endtask
   task automatic t_reset;
      for (int p = 1; p <= 3; p++) begin
         rc(p, 8'h2c, 8'h80);
         rc(p, 8'h2d, 8'h80);
         rc(p, 8'h2e, 8'h01);
         rc(p, 8'h2f, 8'h27);
      end
      chk("outputs", 8'h07, {5'h0, hw_exchange_run});
   endtask
   task automatic t_ctrl;
      u_host.wr(8'h21, 8'h2c, 8'hff);
      rc(1, 8'h2c, 8'h80);
      u_host.wr(8'h21, 8'h2c, 8'h00);
      rc(1, 8'h2c, 8'h00);
      chk("ten off", 8'h06, {5'h0, ten_base_low_power_off});
   endtask
   task automatic t_idle;
      {tx_idle_pin[1], rx_idle_pin[1]} = 2'b11;
      repeat (8) @(negedge sys_clk);
      chk("hold", 8'h02, {5'h0, mac_tx_hold});
      rc(2, 8'h2d, 8'hbc);
      rc(2, 8'h2d, 8'hbc);
      {tx_idle_pin[1], rx_idle_pin[1]} = 2'b00;
      repeat (8) @(negedge sys_clk);
      rc(2, 8'h2d, 8'ha8);
      rc(2, 8'h2d, 8'h80);
   endtask
   task automatic t_wake(input int p, input logic [7:0] v);
      u_host.wr({4'h2, 4'(p + 1)}, 8'h2f, v);
      rc(p + 1, 8'h2f, v);
      tx_idle_pin[p] = 1'b1;
      repeat (8) @(negedge sys_clk);
      tx_idle_pin[p] = 1'b0;
      repeat ((v - 1) * 16) @(negedge sys_clk);
      chk("wake wait", 8'h01, {7'h0, mac_tx_hold[p]});
      repeat (24) @(negedge sys_clk);
      chk("wake done", 8'h00, {7'h0, mac_tx_hold[p]});
   endtask
   task automatic wc(input logic [7:0] v, e);
      u_host.wr(8'h21, 8'h2d, v);
      repeat (8) @(negedge sys_clk);
      chk("enable", e,
          {6'h0, hw_exchange_run[0], fast_low_power_on[0]});
   endtask
   task automatic t_hw;
      np_match_pin[0] = 1'b1;
      repeat (8) @(negedge sys_clk);
      // transmit sticky still set from the port 1 wake scenario
      rc(1, 8'h2d, 8'he1);
      wc(8'h00, 8'h00);
      wc(8'h03, 8'h01);
      rc(1, 8'h2d, 8'h03);
      wc(8'h02, 8'h00);
      np_match_pin[0] = 1'b0;
   endtask
   task automatic t_refuse;
      u_host.wr(8'h42, 8'h2c, 8'h00);
      // output copy trails the register by one edge
      repeat (2) @(negedge sys_clk);
      chk("bad space", 8'h06, {5'h0, ten_base_low_power_off});
      u_host.wr(8'h20, 8'h2c, 8'h00);
      u_host.wr(8'h24, 8'h2c, 8'h00);
      u_host.wr(8'h23, 8'h2c, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk("port route", 8'h02, {5'h0, ten_base_low_power_off});
      rc(2, 8'h30, 8'h00);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      nrst = 1'b0;
      {tx_idle_pin, rx_idle_pin, np_match_pin} = 9'h0;
      repeat (12) @(negedge sys_clk);
      nrst = 1'b1;
      t_reset;
      t_ctrl;
      t_idle;
      t_wake(0, 8'h27);
      t_wake(2, 8'h03);
      t_hw;
      t_refuse;
      end_sim;
   end
endmodule
`default_nettype wire
